// [include/pcs_pkg.sv]
// constants and carriers for the management control/status register pair
// Notes on behaviour
// R1: with negotiation disabled, a write setting the restart bit is ignored.
// R2: negotiation enabled: restart bit restarts it, then self-clears once it begins; code ignores the write in hardware mode.
// R3: hardware mode: duplex bit ignored, duplex strap sets mode, status shows it.
// R4: software mode, negotiation on: duplex taken from negotiated result.
// R5: software mode, negotiation off: duplex bit zero half, one full.
// R6: in loopback the duplex bit has no effect on operation.
// R7: collision test bit zero (default): collision output does not follow transmit enable.
// R8: collision test bit one: collision follows transmit enable, even in loopback.
// R9: collision rises within 512 bit times, falls within 4 bit times.
// R10: reserved control bits 6..0 always read zero.
// R11: station writes default values into all reserved bits on every write.
// R12: status register is 16 bits at management address 0x01.
// R13: any reset loads every status bit with its default.
// R14: four-pair 100 Mb ability bit is fixed at zero.
// R15: 100 Mb full-duplex ability resets to one and is override-writable.
// R16: override-writable bits accept writes only while override enable is one.
// R17: preamble suppression bit resets to zero; one means no preamble needed.
// R18: negotiation-complete bit is latching-high.
// R19: remote-fault bit is latching-high.
// R20: latched remote fault clears on a read of either register holding it.
// R21: negotiation-ability and extended-capability bits always read one.
// R22: link-status bit is latching-low: one valid, zero invalid.
// R23: latched bits hold until read, then follow live; jabber is latching-high.
package pcs_pkg;

  localparam logic [4:0]  CTRL_ADDR       = 5'h00;
  localparam logic [4:0]  STATUS_ADDR     = 5'h01;
  localparam logic [4:0]  DETAIL_ADDR     = 5'h11;

  // control register field positions
  localparam int          CTRL_RESTART    = 9;
  localparam int          CTRL_DUPLEX     = 8;
  localparam int          CTRL_COLTEST    = 7;
  localparam logic [15:0] CTRL_LOW_RESET  = 16'h0000;

  // status register field positions
  localparam int          ST_T4           = 15;
  localparam int          ST_ABIL_HI      = 14;
  localparam int          ST_ABIL_LO      = 6;
  localparam int          ST_AN_DONE      = 5;
  localparam int          ST_RFAULT       = 4;
  localparam int          ST_AN_ABLE      = 3;
  localparam int          ST_LINK         = 2;
  localparam int          ST_JABBER       = 1;
  localparam int          ST_EXT_CAP      = 0;
  localparam logic [15:0] STATUS_RESET    = 16'h7809;
  localparam logic [8:0]  ABIL_RESET      = 9'h1E0;

  // collision test timing
  localparam int          CLK_PERIOD_PS   = 5000;
  localparam int          BIT_TIME_PS     = 10000;
  localparam int          COL_RISE_BT     = 512;
  localparam int          COL_FALL_BT     = 4;
  localparam int          COL_RISE_CYC    =
    COL_RISE_BT * BIT_TIME_PS / CLK_PERIOD_PS;
  localparam int          COL_FALL_CYC    =
    COL_FALL_BT * BIT_TIME_PS / CLK_PERIOD_PS;
  localparam int          SYNC_STAGES     = 3;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pcs_reg_req_s;

  typedef struct packed {
    logic        an_done;
    logic        remote_fault;
    logic        link_ok;
    logic        jabber;
  } pcs_live_s;

endpackage

// [src/pcs_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
module pcs_pin_sync (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      level
);
  import pcs_pkg::*;

  logic [SYNC_STAGES-1:0] stage;
  logic [SYNC_STAGES-1:0] next_stage;
  logic                   next_level;

  // stage[0] feeds only stage[1]; the filter looks at stages 1 and 2
  always_comb begin
    next_stage = {stage[SYNC_STAGES-2:0], pin};
    next_level = level;
    if (stage[1] == stage[2]) begin
      next_level = stage[1];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage <= '0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

endmodule

// [src/pcs_regs.sv]
// control low bits and status register of the management register set
module pcs_regs (
  input  wire logic                  ref_clk,
  input  wire logic                  sys_rst,
  input  wire pcs_pkg::pcs_reg_req_s mgmt,
  output logic [15:0]                rd_data,
  input  wire logic                  config_source_strap,
  input  wire logic                  duplex_strap_pin,
  input  wire logic                  an_enable,
  input  wire logic                  loopback,
  input  wire logic [5:0]            ctrl_upper,
  input  wire logic                  ovr_write_en,
  input  wire pcs_pkg::pcs_live_s    live,
  input  wire logic                  an_duplex,
  input  wire logic                  an_started,
  input  wire logic                  txen,
  input  wire logic                  media_col,
  output logic                       col,
  output logic                       an_restart,
  output logic                       full_duplex,
  output logic                       remote_fault_latched,
  output logic                       link_status_latched
);
  import pcs_pkg::*;

  logic        sw_mode;
  logic        dpx_pin;
  logic        txen_s;

  pcs_pin_sync u_sync_mode (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin     (config_source_strap),
    .level   (sw_mode)
  );

  pcs_pin_sync u_sync_dpx (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin     (duplex_strap_pin),
    .level   (dpx_pin)
  );

  // four cycles of sync stays well inside the 8-cycle fall limit
  pcs_pin_sync u_sync_txen (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .pin     (txen),
    .level   (txen_s)
  );

  // ---------------- control bits ----------------
  logic        restart_bit;
  logic        duplex_bit;
  logic        coltest_bit;
  logic        next_restart_bit;
  logic        next_duplex_bit;
  logic        next_coltest_bit;
  logic        next_an_restart;
  logic        wr_ctrl;
  logic        an_allowed;

  always_comb begin
    wr_ctrl          = mgmt.wr && (mgmt.addr == CTRL_ADDR);
    an_allowed       = sw_mode && an_enable;
    next_restart_bit = restart_bit;
    next_duplex_bit  = duplex_bit;
    next_coltest_bit = coltest_bit;
    next_an_restart  = 1'b0;
    if (an_started) begin
      next_restart_bit = 1'b0; // R2
    end
    if (wr_ctrl) begin
      next_duplex_bit  = mgmt.wdata[CTRL_DUPLEX];
      next_coltest_bit = mgmt.wdata[CTRL_COLTEST];
      // a write of one with negotiation off is dropped
      if (mgmt.wdata[CTRL_RESTART] && an_allowed) begin // R1
        next_restart_bit = 1'b1; // R2
        next_an_restart  = 1'b1; // R2
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      restart_bit <= CTRL_LOW_RESET[CTRL_RESTART];
      duplex_bit  <= CTRL_LOW_RESET[CTRL_DUPLEX];
      coltest_bit <= CTRL_LOW_RESET[CTRL_COLTEST];
      an_restart  <= 1'b0;
    end else begin
      restart_bit <= next_restart_bit;
      duplex_bit  <= next_duplex_bit;
      coltest_bit <= next_coltest_bit;
      an_restart  <= next_an_restart;
    end
  end

  // ---------------- duplex and collision ----------------
  logic next_full_duplex;
  logic next_col;

  always_comb begin
    if (!sw_mode) begin
      next_full_duplex = dpx_pin; // R3
    end else if (an_enable) begin
      next_full_duplex = an_duplex; // R4
    end else if (loopback) begin
      // loopback holds half duplex whatever the bit says
      next_full_duplex = 1'b0; // R6
    end else begin
      next_full_duplex = duplex_bit; // R5
    end
    if (coltest_bit) begin
      next_col = txen_s; // R8 R9
    end else begin
      // media collision is masked in loopback
      next_col = media_col && !loopback; // R7
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      full_duplex <= 1'b0;
      col         <= 1'b0;
    end else begin
      full_duplex <= next_full_duplex;
      col         <= next_col;
    end
  end

  // ---------------- status bits ----------------
  logic [8:0]  abil;
  logic        an_done_l;
  logic        rfault_l;
  logic        link_l;
  logic        jabber_l;
  logic [8:0]  next_abil;
  logic        next_an_done_l;
  logic        next_rfault_l;
  logic        next_link_l;
  logic        next_jabber_l;
  logic        rd_status;
  logic        rd_detail;
  logic        wr_status;
  logic        an_done_live;
  logic [15:0] status_word;
  logic [15:0] ctrl_word;
  logic [15:0] next_rd_data;

  always_comb begin
    rd_status    = mgmt.rd && (mgmt.addr == STATUS_ADDR); // R12
    rd_detail    = mgmt.rd && (mgmt.addr == DETAIL_ADDR);
    wr_status    = mgmt.wr && (mgmt.addr == STATUS_ADDR);
    an_done_live = live.an_done && an_enable;
    next_abil    = abil;
    if (wr_status && ovr_write_en) begin // R16
      next_abil = mgmt.wdata[ST_ABIL_HI:ST_ABIL_LO]; // R15 R17
    end
    // live event wins over the clear caused by a read
    next_an_done_l = an_done_live || (an_done_l && !rd_status); // R18 R23
    next_rfault_l  = live.remote_fault ||
                     (rfault_l && !(rd_status || rd_detail)); // R19 R20
    next_jabber_l  = live.jabber || (jabber_l && !rd_status); // R23
    // a drop wins: link reads low until read after recovery
    next_link_l    = live.link_ok && (link_l || rd_status); // R22
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      abil      <= ABIL_RESET; // R13
      an_done_l <= STATUS_RESET[ST_AN_DONE];
      rfault_l  <= STATUS_RESET[ST_RFAULT];
      link_l    <= STATUS_RESET[ST_LINK];
      jabber_l  <= STATUS_RESET[ST_JABBER];
    end else begin
      abil      <= next_abil;
      an_done_l <= next_an_done_l;
      rfault_l  <= next_rfault_l;
      link_l    <= next_link_l;
      jabber_l  <= next_jabber_l;
    end
  end

  // ---------------- read data ----------------
  always_comb begin
    status_word                          = 16'h0000;
    status_word[ST_T4]                   = 1'b0; // R14
    status_word[ST_ABIL_HI:ST_ABIL_LO]   = abil;
    status_word[ST_AN_DONE]              = an_done_l;
    status_word[ST_RFAULT]               = rfault_l;
    status_word[ST_AN_ABLE]              = 1'b1; // R21
    status_word[ST_LINK]                 = link_l;
    status_word[ST_JABBER]               = jabber_l;
    status_word[ST_EXT_CAP]              = 1'b1; // R21
    ctrl_word                            = 16'h0000; // R10
    ctrl_word[15:10]                     = ctrl_upper;
    ctrl_word[CTRL_RESTART]              = restart_bit;
    ctrl_word[CTRL_DUPLEX]               = duplex_bit;
    ctrl_word[CTRL_COLTEST]              = coltest_bit;
    next_rd_data = rd_data;
    if (mgmt.rd) begin
      unique case (mgmt.addr)
        CTRL_ADDR:   next_rd_data = ctrl_word;
        STATUS_ADDR: next_rd_data = status_word;
        default:     next_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // shared with the detailed-status register built elsewhere
  assign remote_fault_latched = rfault_l;
  assign link_status_latched  = link_l;

endmodule

// [tb/pcs_regs_chk.sv]
// port assertions for the control/status register block
module pcs_regs_chk (
  input wire logic                  ref_clk,
  input wire logic                  sys_rst,
  input wire pcs_pkg::pcs_reg_req_s mgmt,
  input wire logic [15:0]           rd_data,
  input wire logic                  config_source_strap,
  input wire logic                  duplex_strap_pin,
  input wire logic                  an_enable,
  input wire logic                  loopback,
  input wire pcs_pkg::pcs_live_s    live,
  input wire logic                  an_duplex,
  input wire logic                  txen,
  input wire logic                  media_col,
  input wire logic                  col,
  input wire logic                  an_restart,
  input wire logic                  full_duplex,
  input wire logic                  remote_fault_latched,
  input wire logic                  link_status_latched
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  // shadow of collision test (1) and duplex (0) control bits
  logic [1:0] cs;
  logic [1:0] next_cs;
  logic       wc;
  assign wc = mgmt.wr && mgmt.addr == CTRL_ADDR;
  always_comb next_cs = wc ? {mgmt.wdata[7], mgmt.wdata[8]} : cs;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) cs <= 2'b00;
    else cs <= next_cs;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_restart_blocked: assert property (wc && mgmt.wdata[9] && !an_enable
    |=> !an_restart) else $error("restart taken with negotiation off");
  a_restart_taken: assert property (wc && mgmt.wdata[9] && an_enable
    && config_source_strap |=> an_restart) else $error("restart lost");
  a_duplex_hw: assert property ((!config_source_strap
    && $stable(duplex_strap_pin))[*6] |-> full_duplex == duplex_strap_pin)
    else $error("duplex not from strap");
  a_duplex_neg: assert property ((config_source_strap && an_enable
    && !loopback && $stable(an_duplex))[*6] |-> full_duplex == an_duplex)
    else $error("duplex not negotiated");
  a_duplex_sw: assert property ((config_source_strap && !an_enable
    && !loopback && !mgmt.wr)[*6] |-> full_duplex == cs[0])
    else $error("duplex not from control bit");
  a_duplex_loop: assert property ((config_source_strap && !an_enable
    && loopback)[*5] |-> !full_duplex) else $error("duplex in loopback");
  a_col_quiet: assert property ((!cs[1] && !media_col)[*5] |-> !col)
    else $error("collision follows transmit");
  a_col_rise: assert property ((cs[1] && txen)[*8] |-> col)
    else $error("collision late");
  a_col_fall: assert property ($fell(txen) ##0 (!txen && !media_col)[*8]
    |-> !col) else $error("collision held");
  a_ctrl_resv: assert property (mgmt.rd && mgmt.addr == CTRL_ADDR
    |=> rd_data[6:0] == 7'h00) else $error("reserved bits set");
  a_status_fixed: assert property (mgmt.rd
    && mgmt.addr == STATUS_ADDR
    |=> !rd_data[15] && rd_data[3] && rd_data[0]) else $error("fixed bits");
  a_link_low: assert property (!live.link_ok |=> !link_status_latched)
    else $error("link drop lost");
  a_fault_high: assert property (live.remote_fault
    |=> remote_fault_latched) else $error("fault lost");
  a_fault_clear: assert property (mgmt.rd && mgmt.addr == DETAIL_ADDR
    && !live.remote_fault |=> !remote_fault_latched) else $error("no clear");
endmodule

bind pcs_regs pcs_regs_chk pcs_regs_chk_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .mgmt(mgmt), .rd_data(rd_data),
  .config_source_strap(config_source_strap), .loopback(loopback),
  .duplex_strap_pin(duplex_strap_pin), .an_enable(an_enable),
  .live(live), .an_duplex(an_duplex), .txen(txen), .media_col(media_col),
  .col(col), .an_restart(an_restart), .full_duplex(full_duplex),
  .remote_fault_latched(remote_fault_latched),
  .link_status_latched(link_status_latched)
);

// [tb/pcs_station.sv]
// management station model driving the register request port
module pcs_station (
  input  wire logic                 ref_clk,
  output pcs_pkg::pcs_reg_req_s     mgmt,
  input  wire logic [15:0]          rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  initial mgmt = '{1'b0, 1'b0, 5'h1F, 16'hFFFF};
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == CTRL_ADDR) ? (d & 16'hFF80) :
      (a == STATUS_ADDR) ? (d & 16'hF87F) : d;
    @(posedge ref_clk);
    mgmt <= '{1'b0, 1'b1, a, v};
    @(posedge ref_clk);
    // released lines show junk, not the last value
    mgmt <= '{1'b0, 1'b0, ~a, ~v};
    #1;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    mgmt <= '{1'b1, 1'b0, a, 16'h5A5A};
    @(posedge ref_clk);
    mgmt <= '{1'b0, 1'b0, ~a, 16'hA5A5};
    #1;
    d = rd_data;
  endtask
endmodule

// [tb/tb_top.sv]
// self-checking bench for the control/status register block
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pcs_pkg::*;
  logic         ref_clk, sys_rst, config_source_strap, duplex_strap_pin;
  logic         an_enable, loopback, ovr_write_en, an_duplex, an_started;
  logic         txen, col, an_restart, full_duplex;
  logic [15:0]  rd_data, d;
  pcs_reg_req_s mgmt;
  pcs_live_s    live;
  int           fails = 0;
  int           tests_run = 0;
  // strap, neg enable, loopback, duplex pin, neg duplex, control bit, result
  logic [6:0]   dt [7] = '{7'h43, 7'h40, 7'h52, 7'h65, 7'h62, 7'h09, 7'h02};
  always #2.5 ref_clk = ~ref_clk;
  pcs_station pcs_station_inst (.ref_clk(ref_clk), .mgmt(mgmt),
    .rd_data(rd_data));
  pcs_regs pcs_regs_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .mgmt(mgmt),
    .rd_data(rd_data), .config_source_strap(config_source_strap),
    .duplex_strap_pin(duplex_strap_pin), .an_enable(an_enable),
    .loopback(loopback), .ctrl_upper(6'h00), .ovr_write_en(ovr_write_en),
    .live(live), .an_duplex(an_duplex), .an_started(an_started),
    .txen(txen), .media_col(1'b0), .col(col), .an_restart(an_restart),
    .full_duplex(full_duplex), .remote_fault_latched(),
    .link_status_latched());
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic rs(input logic [4:0] a, input logic [15:0] e);
    pcs_station_inst.rd(a, d);
    `CHK(d, e)
  endtask
  task automatic blip(input logic [3:0] p);
    @(posedge ref_clk);
    live <= live ^ p;
    @(posedge ref_clk);
    live <= live ^ p;
  endtask
  task automatic wait_col(input logic v, input int n);
    // step off the launching edge before the first look
    #1;
    for (int i = 0; i < n && col !== v; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (col !== v) begin
      fails++;
      end_sim();
    end
    `CHK(col, v)
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {ref_clk, sys_rst, config_source_strap, duplex_strap_pin} = 4'hE;
    {an_enable, loopback, ovr_write_en, an_duplex, an_started} = 5'h00;
    txen = 1'b0;
    live = '{1'b0, 1'b0, 1'b1, 1'b0};
    cyc(3);
    sys_rst <= 1'b0;
    cyc(4);
    rs(STATUS_ADDR, STATUS_RESET);
    rs(STATUS_ADDR, 16'h780D);
    blip(4'b0010);
    rs(STATUS_ADDR, 16'h7809);
    cyc(1);
    an_enable <= 1'b1;
    blip(4'b1101);
    rs(STATUS_ADDR, 16'h783F);
    rs(STATUS_ADDR, 16'h780D);
    blip(4'b0100);
    pcs_station_inst.rd(DETAIL_ADDR, d);
    rs(STATUS_ADDR, 16'h780D);
    pcs_station_inst.wr(STATUS_ADDR, 16'h3849);
    rs(STATUS_ADDR, 16'h780D);
    cyc(1);
    ovr_write_en <= 1'b1;
    pcs_station_inst.wr(STATUS_ADDR, 16'h3849);
    rs(STATUS_ADDR, 16'h384D);
    pcs_station_inst.wr(STATUS_ADDR, STATUS_RESET);
    pcs_station_inst.wr(CTRL_ADDR, 16'h0200);
    `CHK(an_restart, 1'b1)
    rs(CTRL_ADDR, 16'h0200);
    cyc(1);
    an_started <= 1'b1;
    cyc(1);
    an_started <= 1'b0;
    rs(CTRL_ADDR, 16'h0000);
    cyc(1);
    an_enable <= 1'b0;
    pcs_station_inst.wr(CTRL_ADDR, 16'h0200);
    `CHK(an_restart, 1'b0)
    rs(CTRL_ADDR, 16'h0000);
    foreach (dt[i]) begin
      cyc(1);
      {config_source_strap, an_enable, loopback, duplex_strap_pin,
        an_duplex} <= dt[i][6:2];
      pcs_station_inst.wr(CTRL_ADDR, {7'h00, dt[i][1], 8'h00});
      cyc(6);
      #1;
      `CHK(full_duplex, dt[i][0])
    end
    cyc(1);
    {config_source_strap, an_enable, txen} <= 3'b101;
    cyc(10);
    #1;
    `CHK(col, 1'b0)
    for (int k = 0; k < 2; k++) begin
      pcs_station_inst.wr(CTRL_ADDR, 16'h0080);
      wait_col(1'b1, 1024);
      cyc(1);
      txen <= 1'b0;
      wait_col(1'b0, 8);
      cyc(1);
      {loopback, txen} <= 2'b11;
    end
    end_sim();
  end
endmodule
